// >>> hawc_consts.vh
// constants for the halt-mode and auto wake-up controller
// assumes inclusion by bare name from every design file of the block
`ifndef HAWC_CONSTS_VH
`define HAWC_CONSTS_VH

// =====================================================
// register indexes (byte address is four times the index)
`define HAWC_IDX_AWU_CSR 8'h2b
`define HAWC_IDX_AWU_PRESC 8'h2c
`define HAWC_IDX_CFG 8'h2d
`define HAWC_IDX_STATUS 8'h2e

// =====================================================
// reset values
`define HAWC_CSR_RESET 8'h00
`define HAWC_PRESC_RESET 8'hff
`define HAWC_CFG_RESET 8'h00

// =====================================================
// field positions of the control/status register
`define HAWC_CSR_FLAG_BIT 2
`define HAWC_CSR_MEAS_BIT 1
`define HAWC_CSR_EN_BIT 0

// field positions of the configuration register
`define HAWC_CFG_RTCIE_BIT 0
`define HAWC_CFG_SHORT_BIT 1
`define HAWC_CFG_WDGOPT_BIT 2

// =====================================================
// instruction and interrupt mask codes
`define HAWC_HALT_OPCODE 8'h8e
`define HAWC_MASK_WAKE 2'h2

// =====================================================
// timing: delays are in cpu cycles, one cpu cycle per clock
`define HAWC_STARTUP_SHORT_CPU 13'd256
`define HAWC_STARTUP_LONG_CPU 13'd4096
`define HAWC_CPU_PER_CLOCK 13'd1
`define HAWC_STARTUP_SHORT_CYC (`HAWC_STARTUP_SHORT_CPU * `HAWC_CPU_PER_CLOCK)
`define HAWC_STARTUP_LONG_CYC (`HAWC_STARTUP_LONG_CPU * `HAWC_CPU_PER_CLOCK)

// fixed divider in front of the wake-up prescaler, in rc clock edges
`define HAWC_FIXED_DIV 6'h20

`endif

// >>> hawc_core_model.sv
// core mask bits and wake-up rc oscillator facing the controller
// assumes the bench clock; everything moves on rising edges
`default_nettype none
// =====================================================
// partner model
module hawc_core_model #(
   parameter int RC_HALF = 2
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // from the controller
   input wire logic rcOscEnable,
   input wire logic ccMaskLoad,
   input wire logic [1:0] ccMaskValue,
   // to the controller
   output var logic rcClockIn,
   output var logic [1:0] ccMaskNow
);
   timeunit 1ns;
   timeprecision 1ps;
   int rcCount;

   // mask follows every load; reset leaves all interrupts masked
   always @(posedge clock) begin
      if (!reset_n) begin
         ccMaskNow <= 2'h3;
      end else if (ccMaskLoad) begin
         ccMaskNow <= ccMaskValue;
      end
   end

   // rc clock stands still while disabled, so a stray enable shows
   always @(posedge clock) begin
      if (!reset_n || !rcOscEnable) begin
         rcCount <= 0;
         rcClockIn <= 1'b0;
      end else if (rcCount == RC_HALF - 1) begin
         rcCount <= 0;
         rcClockIn <= !rcClockIn;
      end else begin
         rcCount <= rcCount + 1;
      end
   end
endmodule // hawc_core_model
`default_nettype wire

// >>> hawc_ctrl.v
// halt-mode and auto wake-up controller with an ahb-lite register slave
// assumes a single ahb-lite master, synchronous core strobes, rc clock
// sampled as an ordinary synchronous input
//
// Notes on behaviour
// [R1] opcode 8Eh on the core's opcode port starts halt entry.
// [R2] enable clear: rtc irq enable 0 gives halt, 1 gives active halt.
// [R3] auto wake-up enable set, rtc irq enable clear: auto wake-up halt.
// [R4] plain halt leaves only on reset or a halt-exit interrupt.
// [R5] active halt leaves on rtc, halt-exit irq or reset; reset adds delay.
// [R6] active halt left by interrupt skips the oscillator start-up delay.
// [R7] entering active or auto wake-up halt forces mask bits to 10b.
// [R8] active halt keeps only main oscillator and real-time base clocked.
// [R9] with active halt enabled, halt never causes a watchdog reset.
// [R10] rc clock feeds fixed divider then prescaler, which sets sleep time.
// [R11] wake delay over: set flag, raise irq, restart oscillator, delay, serve.
// [R12] reading the control/status register clears flag and its irq.
// [R13] measure bit in run mode enables rc oscillator, routes it to capture.
// [R14] auto wake-up halt also leaves on any halt-exit irq or reset.
// [R15] auto wake-up halt stops main oscillator and all peripheral clocks.
// [R16] watchdog halt option decides watchdog reset in halt or auto halt.
// [R17] control/status resets 00h; 7:3 zero, 2 flag, 1 measure, 0 enable.
// [R18] software sets and clears the enable bit; sleep then uses prescaler.
// [R19] before serving a wake irq push flags, load priority, restore on pop.
// [R20] software should prepare wake pin and clear pending flags first.
// [R21] plain halt exit restarts oscillator, waits 256 or 4096 cycles.
// [R22] prescaler divides by its value 01h..FFh; 00h forbidden; resets FFh.
// [R23] prescaler zero at auto halt entry raises the wake irq at once.
`default_nettype none
`include "hawc_consts.vh"

module hawc_ctrl (
   // clock and reset
   input wire clock,
   input wire reset_n,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // core instruction stream and mask
   input wire opcodeValid,
   input wire [7:0] opcodeByte,
   input wire [1:0] ccMaskNow,
   input wire [1:0] irqPriority,
   input wire ccPop,
   output reg ccMaskLoad,
   output reg [1:0] ccMaskValue,
   output reg ccPush,
   // wake sources and watchdog state
   input wire haltWakeIrq,
   input wire rtcIrq,
   input wire wakeReset,
   input wire watchdogActive,
   // wake-up rc oscillator
   input wire rcClockIn,
   // power and clock control
   output reg coreRun,
   output reg mainOscEnable,
   output reg rtcClockEnable,
   output reg periphClockEnable,
   output reg rcOscEnable,
   output reg timerCaptureOne,
   // core events
   output reg wakeIrq,
   output reg resumeReset,
   output reg watchdogResetReq,
   output reg [2:0] modeCode
);

   // =====================================================
   // power states
   localparam [2:0] ST_RUN = 3'h0;
   localparam [2:0] ST_HALT = 3'h1;
   localparam [2:0] ST_ACT_HALT = 3'h2;
   localparam [2:0] ST_AWU_HALT = 3'h3;
   localparam [2:0] ST_STARTUP = 3'h4;
   localparam [2:0] ST_SERVICE = 3'h5;

   localparam [12:0] SHORT_LOAD = `HAWC_STARTUP_SHORT_CYC - 13'd1;
   localparam [12:0] LONG_LOAD = `HAWC_STARTUP_LONG_CYC - 13'd1;
   localparam [7:0] CSR_RST = `HAWC_CSR_RESET;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [12:0] delayCount;
   reg wakeByReset;
   reg next_wakeByReset;
   reg loadDelay;

   // register storage
   reg awuEnable;
   reg measureEnable;
   reg wakeFlag;
   reg [7:0] wakePrescaler;
   reg rtcIrqEnable;
   reg startupShort;
   reg watchdogHaltOption;
   reg [1:0] savedMask;

   // bus data phase
   reg dataWrite;
   reg [7:0] dataIndex;
   reg dataHit;

   // rc edge detect and decoded events
   reg rcPrev;
   wire rcTick;
   wire wakeExpire;
   wire haltOp;
   wire addrPhase;
   wire addrOk;
   wire [7:0] addrIndex;
   wire csrReadNow;
   wire flagSet;
   wire enterAwuZero;
   wire wdgTrip;

   // =====================================================
   // ahb address phase decode
   assign addrPhase = hsel && hready && htrans[1];
   assign addrIndex = haddr[9:2];
   assign addrOk = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
   assign csrReadNow = addrPhase && !hwrite && addrOk &&
                       (addrIndex == `HAWC_IDX_AWU_CSR);

   // halt instruction decode
   assign haltOp = (state == ST_RUN) && opcodeValid &&
                   (opcodeByte == `HAWC_HALT_OPCODE); // [R1]

   // forbidden prescaler value wakes at once instead of sleeping
   assign enterAwuZero = haltOp && awuEnable && !rtcIrqEnable &&
                         (wakePrescaler == 8'h00) && !wdgTrip; // [R23]

   // watchdog reset only outside active halt, and only if the option says so
   assign wdgTrip = haltOp && watchdogActive && !rtcIrqEnable &&
                    !watchdogHaltOption; // [R9] [R16]

   assign flagSet = ((state == ST_AWU_HALT) && wakeExpire) || enterAwuZero; // [R11]

   // rc clock taken as a synchronous input, edges counted by the timer
   assign rcTick = rcClockIn && !rcPrev;

   // =====================================================
   // wake delay timer runs only while asleep in auto wake-up halt
   hawc_wake_timer wakeTimer (
      .clock(clock),
      .reset_n(reset_n),
      .run(state == ST_AWU_HALT),
      .rcTick(rcTick),
      .prescale(wakePrescaler),
      .expire(wakeExpire)
   );

   // =====================================================
   // next state
   always @* begin
      next_state = state;
      next_wakeByReset = wakeByReset;
      loadDelay = 1'b0;
      case (state)
         ST_RUN: begin
            if (haltOp && !wdgTrip && !enterAwuZero) begin
               if (rtcIrqEnable) begin
                  next_state = ST_ACT_HALT; // [R2]
               end else if (awuEnable) begin
                  next_state = ST_AWU_HALT; // [R3]
               end else begin
                  next_state = ST_HALT; // [R2]
               end
            end
         end
         ST_HALT: begin
            // only reset or a halt-exit interrupt ends it
            if (wakeReset || haltWakeIrq) begin // [R4]
               next_state = ST_STARTUP; // [R21]
               next_wakeByReset = wakeReset;
               loadDelay = 1'b1;
            end
         end
         ST_ACT_HALT: begin
            if (wakeReset) begin
               next_state = ST_STARTUP; // [R5]
               next_wakeByReset = 1'b1;
               loadDelay = 1'b1;
            end else if (rtcIrq || haltWakeIrq) begin
               // oscillator never stopped, so no stabilisation wait
               next_state = ST_SERVICE; // [R6]
               next_wakeByReset = 1'b0;
            end
         end
         ST_AWU_HALT: begin
            if (wakeReset || haltWakeIrq || wakeExpire) begin // [R14] [R11]
               next_state = ST_STARTUP;
               next_wakeByReset = wakeReset;
               loadDelay = 1'b1;
            end
         end
         ST_STARTUP: begin
            if (delayCount == 13'h0000) begin
               next_state = wakeByReset ? ST_RUN : ST_SERVICE; // [R21]
            end
         end
         ST_SERVICE: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   // =====================================================
   // state, cause and start-up delay counter
   always @(posedge clock) begin
      if (!reset_n) begin
         state <= ST_RUN;
         wakeByReset <= 1'b0;
         delayCount <= 13'h0000;
      end else begin
         state <= next_state;
         wakeByReset <= next_wakeByReset;
         if (loadDelay) begin
            delayCount <= startupShort ? SHORT_LOAD : LONG_LOAD; // [R5] [R11] [R21]
         end else if (delayCount != 13'h0000) begin
            delayCount <= delayCount - 13'h0001;
         end
      end
   end

   // =====================================================
   // clock gating from the next state so outputs track the state itself
   always @(posedge clock) begin
      if (!reset_n) begin
         coreRun <= 1'b1;
         mainOscEnable <= 1'b1;
         rtcClockEnable <= 1'b1;
         periphClockEnable <= 1'b1;
         rcOscEnable <= 1'b0;
         timerCaptureOne <= 1'b0;
         modeCode <= ST_RUN;
      end else begin
         coreRun <= (next_state == ST_RUN) || (next_state == ST_SERVICE);
         // main oscillator off only in plain and auto halt
         mainOscEnable <= (next_state != ST_HALT) &&
                          (next_state != ST_AWU_HALT); // [R8] [R15]
         rtcClockEnable <= (next_state != ST_HALT) &&
                           (next_state != ST_AWU_HALT); // [R8]
         periphClockEnable <= (next_state == ST_RUN) ||
                              (next_state == ST_SERVICE); // [R8] [R15]
         rcOscEnable <= (next_state == ST_AWU_HALT) ||
                        ((next_state == ST_RUN) && measureEnable); // [R13] [R15]
         // capture path carries the rc clock only while measuring in run
         timerCaptureOne <= (state == ST_RUN) && measureEnable && rcClockIn; // [R13]
         modeCode <= next_state;
      end
   end

   // =====================================================
   // interrupt mask handling and core event pulses
   always @(posedge clock) begin
      if (!reset_n) begin
         ccMaskLoad <= 1'b0;
         ccMaskValue <= 2'h0;
         ccPush <= 1'b0;
         savedMask <= 2'h0;
         resumeReset <= 1'b0;
         watchdogResetReq <= 1'b0;
      end else begin
         ccMaskLoad <= 1'b0;
         ccPush <= 1'b0;
         resumeReset <= 1'b0;
         watchdogResetReq <= wdgTrip; // [R16]
         if (haltOp && !wdgTrip && !enterAwuZero) begin
            // pending interrupts then wake the part at once
            ccMaskLoad <= 1'b1;
            ccMaskValue <= `HAWC_MASK_WAKE; // [R7]
         end else if (state == ST_SERVICE) begin
            ccPush <= 1'b1; // [R19]
            savedMask <= ccMaskNow;
            ccMaskLoad <= 1'b1;
            ccMaskValue <= irqPriority; // [R19]
         end else if (ccPop) begin
            ccMaskLoad <= 1'b1;
            ccMaskValue <= savedMask; // [R19]
         end
         if ((state == ST_STARTUP) && (delayCount == 13'h0000) && wakeByReset) begin
            resumeReset <= 1'b1;
         end
      end
   end

   // =====================================================
   // wake flag: a set in the same cycle as the read clear wins
   always @(posedge clock) begin
      if (!reset_n) begin
         wakeFlag <= 1'b0;
         wakeIrq <= 1'b0;
         rcPrev <= 1'b0;
      end else begin
         rcPrev <= rcClockIn;
         if (flagSet) begin
            wakeFlag <= 1'b1; // [R11]
            wakeIrq <= 1'b1; // [R11]
         end else if (csrReadNow) begin
            wakeFlag <= 1'b0; // [R12]
            wakeIrq <= 1'b0; // [R12]
         end
      end
   end

   // =====================================================
   // ahb slave: zero wait states, always okay
   always @(posedge clock) begin
      if (!reset_n) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         dataWrite <= 1'b0;
         dataIndex <= 8'h00;
         dataHit <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         dataWrite <= addrPhase && hwrite;
         dataIndex <= addrIndex;
         dataHit <= addrOk;
         if (addrPhase && !hwrite) begin
            // unmapped reads answer zero
            hrdata <= 32'h0000_0000;
            if (addrOk && (addrIndex == `HAWC_IDX_AWU_CSR)) begin
               hrdata[`HAWC_CSR_FLAG_BIT] <= wakeFlag; // [R17]
               hrdata[`HAWC_CSR_MEAS_BIT] <= measureEnable;
               hrdata[`HAWC_CSR_EN_BIT] <= awuEnable;
            end else if (addrOk && (addrIndex == `HAWC_IDX_AWU_PRESC)) begin
               hrdata[7:0] <= wakePrescaler;
            end else if (addrOk && (addrIndex == `HAWC_IDX_CFG)) begin
               hrdata[`HAWC_CFG_RTCIE_BIT] <= rtcIrqEnable;
               hrdata[`HAWC_CFG_SHORT_BIT] <= startupShort;
               hrdata[`HAWC_CFG_WDGOPT_BIT] <= watchdogHaltOption;
            end else if (addrOk && (addrIndex == `HAWC_IDX_STATUS)) begin
               hrdata[2:0] <= state;
               hrdata[3] <= wakeByReset;
            end
         end
      end
   end

   // =====================================================
   // register writes in the data phase; reserved and flag bits ignored
   always @(posedge clock) begin
      if (!reset_n) begin
         awuEnable <= CSR_RST[`HAWC_CSR_EN_BIT]; // [R17]
         measureEnable <= CSR_RST[`HAWC_CSR_MEAS_BIT]; // [R17]
         wakePrescaler <= `HAWC_PRESC_RESET; // [R22]
         rtcIrqEnable <= 1'b0;
         startupShort <= 1'b0;
         watchdogHaltOption <= 1'b0;
      end else if (dataWrite && dataHit) begin
         if (dataIndex == `HAWC_IDX_AWU_CSR) begin
            awuEnable <= hwdata[`HAWC_CSR_EN_BIT]; // [R18]
            measureEnable <= hwdata[`HAWC_CSR_MEAS_BIT]; // [R13]
         end else if (dataIndex == `HAWC_IDX_AWU_PRESC) begin
            // 00h is stored; entry then wakes at once
            wakePrescaler <= hwdata[7:0]; // [R22]
         end else if (dataIndex == `HAWC_IDX_CFG) begin
            rtcIrqEnable <= hwdata[`HAWC_CFG_RTCIE_BIT];
            startupShort <= hwdata[`HAWC_CFG_SHORT_BIT];
            watchdogHaltOption <= hwdata[`HAWC_CFG_WDGOPT_BIT];
         end
      end
   end

   // hsize is always a word here; sub-word writes are treated as word writes

endmodule // hawc_ctrl
`default_nettype wire

// >>> hawc_ctrl_chk.sv
// checker for the halt and auto wake-up controller, on its top ports
// assumes one clock domain and a bind onto every hawc_ctrl instance
`default_nettype none
`include "hawc_consts.vh"
// =====================================================
// checker
module hawc_ctrl_chk (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // core side
   input wire logic opcodeValid,
   input wire logic [7:0] opcodeByte,
   input wire logic [1:0] irqPriority,
   input wire logic ccMaskLoad,
   input wire logic [1:0] ccMaskValue,
   input wire logic ccPush,
   // wake sources
   input wire logic rtcIrq,
   input wire logic haltWakeIrq,
   input wire logic wakeReset,
   // power state
   input wire logic mainOscEnable,
   input wire logic periphClockEnable,
   input wire logic rcOscEnable,
   input wire logic [2:0] modeCode
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [12:0] startCount;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   // start-up length, cleared outside start-up so each stretch counts alone
   always_ff @(posedge clock) begin
      if (!reset_n || modeCode != 3'h4) begin
         startCount <= 13'h0000;
      end else begin
         startCount <= startCount + 13'h0001;
      end
   end

   property p_onlyHalt;
      modeCode == 3'h0 && !(opcodeValid && opcodeByte == `HAWC_HALT_OPCODE) |=> modeCode == 3'h0;
   endproperty
   a_onlyHalt: assert property (p_onlyHalt) else $error("run left without halt");
   property p_mask;
      modeCode == 3'h0 ##1 modeCode inside {3'h2, 3'h3} |-> ccMaskLoad
         && ccMaskValue == `HAWC_MASK_WAKE;
   endproperty
   a_mask: assert property (p_mask) else $error("mask not forced on entry");
   property p_act;
      modeCode == 3'h2 |-> mainOscEnable && !periphClockEnable;
   endproperty
   a_act: assert property (p_act) else $error("wrong clocks in active halt");
   property p_awu;
      modeCode == 3'h3 |-> !mainOscEnable && !periphClockEnable && rcOscEnable;
   endproperty
   a_awu: assert property (p_awu) else $error("wrong clocks in auto halt");
   property p_actIrq;
      modeCode == 3'h2 && !wakeReset && (rtcIrq || haltWakeIrq) |=> modeCode == 3'h5;
   endproperty
   a_actIrq: assert property (p_actIrq) else $error("active halt irq not served");
   property p_plain;
      modeCode == 3'h1 && !haltWakeIrq && !wakeReset |=> modeCode == 3'h1;
   endproperty
   a_plain: assert property (p_plain) else $error("halt left without cause");
   property p_start;
      modeCode != 3'h4 && $past(modeCode) == 3'h4 |-> startCount == 13'h0100
         || startCount == 13'h1000;
   endproperty
   a_start: assert property (p_start) else $error("bad start-up length");
   property p_push;
      ccPush |-> ccMaskLoad && ccMaskValue == $past(irqPriority) && $past(modeCode) == 3'h5;
   endproperty
   a_push: assert property (p_push) else $error("push without priority load");
endmodule // hawc_ctrl_chk

bind hawc_ctrl hawc_ctrl_chk chk (.*);
`default_nettype wire

// >>> hawc_ctrl_tb.sv
// self-checking bench for the halt and auto wake-up controller
// assumes the bound checker and the core model partner
`default_nettype none
`include "hawc_consts.vh"
// =====================================================
// bench
module hawc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] A_CSR = `HAWC_IDX_AWU_CSR * 4;
   localparam logic [31:0] A_PRE = `HAWC_IDX_AWU_PRESC * 4;
   localparam logic [31:0] A_CFG = `HAWC_IDX_CFG * 4;
   logic clock = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic opcodeValid = 1'b0, ccPop = 1'b0, haltWakeIrq = 1'b0, rtcIrq = 1'b0;
   logic wakeReset = 1'b0, watchdogActive = 1'b0, sawReset;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
   logic [1:0] htrans = 2'h0, irqPriority = 2'h1, ccMaskNow, ccMaskValue;
   logic [7:0] opcodeByte = 8'h00;
   logic [2:0] hsize = 3'h2, modeCode;
   logic hready, hresp, ccMaskLoad, ccPush, rcClockIn, coreRun, mainOscEnable;
   logic rtcClockEnable, periphClockEnable, rcOscEnable, timerCaptureOne;
   logic wakeIrq, resumeReset, watchdogResetReq, prevRc;
   int n_fail = 0, comparisons = 0, cyc, haltCyc;

   always #5 clock = ~clock;

   hawc_ctrl uut (.hreadyout(hready), .*);
   hawc_core_model core (.*);

   // one comparison, reported at once on mismatch
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // single ahb-lite transfer: address phase held until hready, then data phase
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clock); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic expectReg(input logic [31:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0000_0000);
      check(rd, exp);
      check(hresp, 1'b0);
   endtask

   // one executed opcode; a watchdog request on either following edge is kept
   task automatic exec(input logic [7:0] op);
      @(posedge clock);
      opcodeValid <= 1'b1;
      opcodeByte <= op;
      @(posedge clock);
      opcodeValid <= 1'b0;
      #1;
      sawReset = watchdogResetReq;
      @(posedge clock);
      #1;
      sawReset |= watchdogResetReq;
   endtask

   // bounded count of cycles spent in one mode
   task automatic waitLeave(input logic [2:0] m);
      cyc = 0;
      while (modeCode === m && cyc < 6000) begin
         @(posedge clock);
         #1;
         cyc++;
      end
   endtask

   // raise wake sources until halt is left, then time start-up and return to run
   task automatic wake(input logic [2:0] src, input int expStart, input logic viaReset);
      @(posedge clock);
      {wakeReset, rtcIrq, haltWakeIrq} <= src;
      waitLeave(modeCode);
      haltCyc = cyc;
      if (expStart != 0) begin
         waitLeave(3'h4);
         check(cyc, expStart);
      end
      check({resumeReset, modeCode}, viaReset ? 4'h8 : 4'h5);
      @(posedge clock);
      {wakeReset, rtcIrq, haltWakeIrq} <= 3'h0;
      #1;
      check(modeCode, 3'h0);
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // watchdog well beyond the longest expected run
   initial begin
      #300000;
      n_fail++;
      conclude();
   end

   // =====================================================
   // test sequence
   initial begin
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      expectReg(A_CSR, 32'h0000_0000);
      expectReg(A_PRE, 32'h0000_00ff);
      expectReg(32'h0000_0000, 32'h0000_0000);
      bus(A_CSR, 1'b1, 32'h0000_00ff);
      expectReg(A_CSR, 32'h0000_0003);
      bus(A_CSR, 1'b1, 32'h0000_0000);
      exec(8'h8f);
      check(modeCode, 3'h0);
      // plain halt, short start-up, then mask pop
      bus(A_CFG, 1'b1, 32'h0000_0002);
      exec(`HAWC_HALT_OPCODE);
      check({coreRun, mainOscEnable, periphClockEnable, modeCode}, 6'h01);
      check(ccMaskNow, `HAWC_MASK_WAKE);
      wake(3'h1, 256, 1'b0);
      @(posedge clock);
      ccPop <= 1'b1;
      #1;
      check(ccMaskNow, irqPriority);
      @(posedge clock);
      ccPop <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      check(ccMaskNow, `HAWC_MASK_WAKE);
      // active halt: interrupt skips start-up, reset does not
      bus(A_CFG, 1'b1, 32'h0000_0003);
      exec(`HAWC_HALT_OPCODE);
      check({rtcClockEnable, mainOscEnable, periphClockEnable, modeCode}, 6'h32);
      wake(3'h2, 0, 1'b0);
      exec(`HAWC_HALT_OPCODE);
      wake(3'h4, 256, 1'b1);
      // plain halt left by reset with the long start-up
      bus(A_CFG, 1'b1, 32'h0000_0000);
      exec(`HAWC_HALT_OPCODE);
      wake(3'h4, 4096, 1'b1);
      expectReg(`HAWC_IDX_STATUS * 4, 32'h0000_0008);
      // auto wake-up: 32 * 2 rc edges of four cycles each
      bus(A_CFG, 1'b1, 32'h0000_0002);
      bus(A_PRE, 1'b1, 32'h0000_0002);
      expectReg(A_PRE, 32'h0000_0002);
      bus(A_CSR, 1'b1, 32'h0000_0001);
      exec(`HAWC_HALT_OPCODE);
      check({rtcClockEnable, mainOscEnable, rcOscEnable, modeCode}, 6'h0b);
      wake(3'h0, 256, 1'b0);
      check(haltCyc >= 248 && haltCyc <= 272, 1'b1);
      check(wakeIrq, 1'b1);
      expectReg(A_CSR, 32'h0000_0005);
      check(wakeIrq, 1'b0);
      expectReg(A_CSR, 32'h0000_0001);
      // forbidden prescaler raises the wake-up at once
      bus(A_PRE, 1'b1, 32'h0000_0000);
      exec(`HAWC_HALT_OPCODE);
      check({wakeIrq, modeCode}, 4'h8);
      expectReg(A_CSR, 32'h0000_0005);
      // measurement routes the rc clock to the capture input
      bus(A_CSR, 1'b1, 32'h0000_0002);
      repeat (4) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         #1;
         prevRc = rcClockIn;
         @(posedge clock);
         #1;
         check({rcOscEnable, timerCaptureOne}, {1'b1, prevRc});
      end
      bus(A_CSR, 1'b1, 32'h0000_0000);
      // watchdog option and active halt against a running watchdog
      watchdogActive <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      check({rcOscEnable, timerCaptureOne}, 2'h0);
      exec(`HAWC_HALT_OPCODE);
      check({sawReset, modeCode}, 4'h8);
      bus(A_CFG, 1'b1, 32'h0000_0006);
      expectReg(A_CFG, 32'h0000_0006);
      exec(`HAWC_HALT_OPCODE);
      check({sawReset, modeCode}, 4'h1);
      wake(3'h1, 256, 1'b0);
      bus(A_CFG, 1'b1, 32'h0000_0003);
      exec(`HAWC_HALT_OPCODE);
      check({sawReset, modeCode}, 4'h2);
      wake(3'h1, 0, 1'b0);
      conclude();
   end
endmodule // hawc_ctrl_tb
`default_nettype wire

// >>> hawc_wake_timer.v
// wake-up delay timer: fixed divider then programmable prescaler
// assumes rcTick is a one-cycle pulse per rising edge of the rc clock
`default_nettype none
`include "hawc_consts.vh"

module hawc_wake_timer (
   // clock and reset
   input wire clock,
   input wire reset_n,
   // control
   input wire run,
   input wire rcTick,
   input wire [7:0] prescale,
   // result
   output reg expire
);

   reg [5:0] divCount;
   reg [7:0] preCount;
   wire divWrap;

   assign divWrap = rcTick && (divCount == (`HAWC_FIXED_DIV - 6'h01));

   // =====================================================
   // divider chain, cleared whenever the sleep is over
   always @(posedge clock) begin
      if (!reset_n || !run) begin
         divCount <= 6'h00;
         preCount <= 8'h00;
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (rcTick) begin
            divCount <= divWrap ? 6'h00 : divCount + 6'h01; // [R10]
         end
         if (divWrap) begin
            // prescaler factor equals its value
            if (preCount == (prescale - 8'h01)) begin // [R22]
               preCount <= 8'h00;
               expire <= 1'b1; // [R10]
            end else begin
               preCount <= preCount + 8'h01;
            end
         end
      end
   end

endmodule // hawc_wake_timer
`default_nettype wire
